//--- tb/dual_dac_serial_command_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_command_port_tb_top;
    logic i_clk;
    logic i_rst_n;
    logic i_async_zero_n;
    logic i_chain_mode_select;
    logic shift_clk;
    logic frame_n;
    logic sdata;
    logic [11:0] o_dac_a;
    logic [11:0] o_dac_b;
    logic [11:0] o_input_a;
    logic [11:0] o_input_b;
    logic o_power_down_valid;
    logic [15:0] o_power_down_word;
    logic o_serial_chain_out;
    logic [15:0] pd_seen;
    logic [15:0] w;
    logic [11:0] d;
    int err_total;
    int check_count;
    int pd_pulses;
    int ia, ib, da, db, rep, c, p, rnd;

    always #50 i_clk = ~i_clk;

    host_link_model u_host_link_model (
        .o_shift_clk(shift_clk),
        .o_frame_n(frame_n),
        .o_data(sdata)
    );

    dual_dac_serial_command_port u_dual_dac_serial_command_port (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_shift_clk(shift_clk),
        .i_frame_n(frame_n),
        .i_serial_word_in(sdata),
        .i_async_zero_n(i_async_zero_n),
        .i_chain_mode_select(i_chain_mode_select),
        .o_dac_a(o_dac_a),
        .o_dac_b(o_dac_b),
        .o_input_a(o_input_a),
        .o_input_b(o_input_b),
        .o_power_down_valid(o_power_down_valid),
        .o_power_down_word(o_power_down_word),
        .o_serial_chain_out(o_serial_chain_out)
    );

    always @(negedge i_clk) begin
        if (o_power_down_valid === 1'b1) begin
            pd_pulses++;
            pd_seen = o_power_down_word;
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic check_regs();
        check("dac_a", {4'h0, o_dac_a}, 16'(da));
        check("dac_b", {4'h0, o_dac_b}, 16'(db));
        check("input_a", {4'h0, o_input_a}, 16'(ia));
        check("input_b", {4'h0, o_input_b}, 16'(ib));
    endtask : check_regs

    task automatic frame(input logic [15:0] word, input int nbits);
        @(posedge i_clk);
        #1;
        u_host_link_model.send(word, nbits);
        if (i_chain_mode_select) begin
            u_host_link_model.chain_edge();
        end
        repeat (6) @(posedge i_clk);
        #1;
    endtask : frame

    task automatic apply(input int cmd, input int v);
        case (cmd)
            0: ia = v;
            1: ib = v;
            2: begin ia = v; da = v; end
            3: begin ia = v; da = v; db = ib; end
            4: begin ib = v; db = v; end
            5: begin ib = v; db = v; da = ia; end
            6: begin ia = v; ib = v; da = v; db = v; end
            default: begin da = ia; db = ib; end
        endcase
    endtask : apply

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    initial begin
        #2000000;
        err_total++;
        $display("unexpected watchdog expired");
        complete_run();
    end

    initial begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        i_async_zero_n = 1'b1;
        i_chain_mode_select = 1'b0;
        {err_total, check_count, pd_pulses, ia, ib, da, db} = '0;
        rnd = $urandom(98174);
        repeat (20) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        check_regs();
        for (rep = 0; rep < 3; rep++) begin
            for (c = 0; c < 8; c++) begin
                d = (rep == 0) ? 12'hfff : 12'($urandom_range(4095, 0));
                w = {c[2:0], 1'b0, d};
                frame(w, 16);
                apply(c, int'(d));
                check_regs();
            end
        end
        frame({3'h6, 1'b0, 12'h5a5}, 15);
        check_regs();
        frame({3'h6, 1'b0, 12'h5a5}, 17);
        check_regs();
        p = pd_pulses;
        w = {3'h6, 1'b1, 12'($urandom_range(4095, 0))};
        frame(w, 16);
        check_regs();
        check("pd_pulses", 16'(pd_pulses - p), 16'h0001);
        check("pd_word", pd_seen, w);
        i_chain_mode_select = 1'b1;
        w = {3'h4, 1'b0, 12'($urandom_range(4095, 0))};
        frame(w, 16);
        apply(4, int'(w[11:0]));
        check_regs();
        check("chain_out", {15'h0000, o_serial_chain_out}, {15'h0000, w[15]});
        i_chain_mode_select = 1'b0;
        frame(w, 16);
        apply(4, int'(w[11:0]));
        check_regs();
        check("chain_out", {15'h0000, o_serial_chain_out}, 16'h0000);
        i_async_zero_n = 1'b0;
        {ia, ib, da, db} = '0;
        #10;
        check_regs();
        repeat (2) @(posedge i_clk);
        #1 i_async_zero_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        check_regs();
        frame({3'h2, 1'b0, 12'h123}, 16);
        apply(2, 12'h123);
        check_regs();
        complete_run();
    end
endmodule : dual_dac_serial_command_port_tb_top
`default_nettype wire

//--- tb/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    output logic o_shift_clk,
    output logic o_frame_n,
    output logic o_data
);
    initial begin
        o_shift_clk = 1'b1;
        o_frame_n = 1'b1;
        o_data = 1'b0;
    end

    // The shift clock stands high outside frames except for the chain-mode edge, which falls with the strobe high and so cannot disturb a pending word.
    task automatic send(input logic [15:0] word, input int nbits);
        int i;
        o_frame_n = 1'b0;
        for (i = 0; i < nbits; i++) begin
            o_data = (i < 16) ? word[15 - i] : 1'b0;
            #32 o_shift_clk = 1'b0;
            #32 o_shift_clk = 1'b1;
        end
        #32 o_frame_n = 1'b1;
        // A released data line shows the inverse, never a stale valid bit.
        o_data = ~o_data;
    endtask : send

    // In chain mode the far side needs one falling edge with the strobe high to clock the word's top bit onto the chain output.
    task automatic chain_edge();
        #32 o_shift_clk = 1'b0;
        #32 o_shift_clk = 1'b1;
    endtask : chain_edge
endmodule : host_link_model
`default_nettype wire

//--- verilog/dac_cmd_pkg.sv
`default_nettype none
package dac_cmd_pkg;
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int COUNT_BITS = 5;
    localparam logic [4:0] WORD_COUNT = 5'h10;
    localparam logic [4:0] COUNT_MAX = 5'h1f;
    localparam int CTRL_MSB = 15;
    localparam int CTRL_LSB = 13;
    localparam int PD_BIT = 12;
    localparam int DATA_MSB = 11;
    localparam logic [11:0] DAC_RESET = 12'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [2:0] CMD_STORE_A = 3'h0;
    localparam logic [2:0] CMD_STORE_B = 3'h1;
    localparam logic [2:0] CMD_UPDATE_A = 3'h2;
    localparam logic [2:0] CMD_UPDATE_A_XFER_B = 3'h3;
    localparam logic [2:0] CMD_UPDATE_B = 3'h4;
    localparam logic [2:0] CMD_UPDATE_B_XFER_A = 3'h5;
    localparam logic [2:0] CMD_UPDATE_ALL = 3'h6;
    localparam logic [2:0] CMD_XFER_ALL = 3'h7;
endpackage : dac_cmd_pkg
`default_nettype wire

//--- verilog/dual_dac_serial_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_command_port #(
    parameter int WORD_BITS = dac_cmd_pkg::WORD_BITS,
    parameter int DATA_BITS = dac_cmd_pkg::DATA_BITS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_shift_clk,
    input wire logic i_frame_n,
    input wire logic i_serial_word_in,
    input wire logic i_async_zero_n,
    input wire logic i_chain_mode_select,
    output logic [DATA_BITS-1:0] o_dac_a,
    output logic [DATA_BITS-1:0] o_dac_b,
    output logic [DATA_BITS-1:0] o_input_a,
    output logic [DATA_BITS-1:0] o_input_b,
    output logic o_power_down_valid,
    output logic [WORD_BITS-1:0] o_power_down_word,
    output logic o_serial_chain_out
);
    typedef struct packed {
        logic frame_s1;
        logic frame_s2;
        logic frame_s3;
        logic [DATA_BITS-1:0] dac_a;
        logic [DATA_BITS-1:0] dac_b;
        logic [DATA_BITS-1:0] in_a;
        logic [DATA_BITS-1:0] in_b;
        logic pd_valid;
        logic [WORD_BITS-1:0] pd_word;
    } port_state_type;

    port_state_type st_ff;
    port_state_type nxt_st;
    logic rst_all_n;
    logic [WORD_BITS-1:0] link_word;
    logic [dac_cmd_pkg::COUNT_BITS-1:0] link_count;
    logic frame_end;
    logic take;
    logic pd_cmd;
    logic [2:0] cmd;
    logic [DATA_BITS-1:0] data;

    if (WORD_BITS != dac_cmd_pkg::WORD_BITS || DATA_BITS != dac_cmd_pkg::DATA_BITS)
    begin : g_check
        $error("Only a 16-bit word carrying a 12-bit code is supported");
    end

    // The clear pin acts like power-on reset: both reach every flop at once.
    assign rst_all_n = i_rst_n & i_async_zero_n;

    serial_link_rx #(
        .WORD_BITS(WORD_BITS)
    ) u_link (
        .i_shift_clk(i_shift_clk),
        .i_rst_n(rst_all_n),
        .i_frame_n(i_frame_n),
        .i_serial_word_in(i_serial_word_in),
        .i_chain_mode_select(i_chain_mode_select),
        .o_word(link_word),
        .o_bit_count(link_count),
        .o_serial_chain_out(o_serial_chain_out)
    );

    // The link word is read only after the strobe rise has passed the
    // synchroniser, when the shift clock has stopped and the word is quiet.
    assign frame_end = st_ff.frame_s2 & ~st_ff.frame_s3;
    assign take = frame_end && (link_count == dac_cmd_pkg::WORD_COUNT);
    assign pd_cmd = link_word[dac_cmd_pkg::PD_BIT];
    assign cmd = link_word[dac_cmd_pkg::CTRL_MSB:dac_cmd_pkg::CTRL_LSB];
    assign data = link_word[dac_cmd_pkg::DATA_MSB:0];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.frame_s1 = i_frame_n;
        nxt_st.frame_s2 = st_ff.frame_s1;
        nxt_st.frame_s3 = st_ff.frame_s2;
        nxt_st.pd_valid = 1'b0;
        if (take) begin
            if (pd_cmd) begin
                nxt_st.pd_valid = 1'b1;
                nxt_st.pd_word = link_word;
            end else begin
                case (cmd)
                    dac_cmd_pkg::CMD_STORE_A: begin
                        nxt_st.in_a = data;
                    end
                    dac_cmd_pkg::CMD_STORE_B: begin
                        nxt_st.in_b = data;
                    end
                    dac_cmd_pkg::CMD_UPDATE_A: begin
                        nxt_st.in_a = data;
                        nxt_st.dac_a = data;
                    end
                    dac_cmd_pkg::CMD_UPDATE_A_XFER_B: begin
                        nxt_st.in_a = data;
                        nxt_st.dac_a = data;
                        nxt_st.dac_b = st_ff.in_b;
                    end
                    dac_cmd_pkg::CMD_UPDATE_B: begin
                        nxt_st.in_b = data;
                        nxt_st.dac_b = data;
                    end
                    dac_cmd_pkg::CMD_UPDATE_B_XFER_A: begin
                        nxt_st.in_b = data;
                        nxt_st.dac_b = data;
                        nxt_st.dac_a = st_ff.in_a;
                    end
                    dac_cmd_pkg::CMD_UPDATE_ALL: begin
                        nxt_st.in_a = data;
                        nxt_st.in_b = data;
                        nxt_st.dac_a = data;
                        nxt_st.dac_b = data;
                    end
                    dac_cmd_pkg::CMD_XFER_ALL: begin
                        nxt_st.dac_a = st_ff.in_a;
                        nxt_st.dac_b = st_ff.in_b;
                    end
                    default: begin
                        nxt_st = nxt_st;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            st_ff.frame_s1 <= 1'b1;
            st_ff.frame_s2 <= 1'b1;
            st_ff.frame_s3 <= 1'b1;
            st_ff.dac_a <= dac_cmd_pkg::DAC_RESET;
            st_ff.dac_b <= dac_cmd_pkg::DAC_RESET;
            st_ff.in_a <= dac_cmd_pkg::DAC_RESET;
            st_ff.in_b <= dac_cmd_pkg::DAC_RESET;
            st_ff.pd_valid <= 1'b0;
            st_ff.pd_word <= dac_cmd_pkg::WORD_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_dac_a = st_ff.dac_a;
    assign o_dac_b = st_ff.dac_b;
    assign o_input_a = st_ff.in_a;
    assign o_input_b = st_ff.in_b;
    assign o_power_down_valid = st_ff.pd_valid;
    assign o_power_down_word = st_ff.pd_word;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_all_n);

    sequence s_frame_rise;
        st_ff.frame_s2 && !st_ff.frame_s3;
    endsequence

    sequence s_full_word(logic [2:0] c);
        s_frame_rise ##0 (link_count == dac_cmd_pkg::WORD_COUNT && !pd_cmd && cmd == c);
    endsequence

    AST_CLEAR_ZERO: assert property (disable iff (!i_rst_n)
        !i_async_zero_n |-> (o_dac_a == 12'h000 && o_dac_b == 12'h000))
        else $error("Converter registers not zero while clear is low.");

    AST_STORE_A: assert property (
        s_full_word(3'h0) |=> (o_input_a == $past(data) && $stable(o_dac_a)
            && $stable(o_dac_b) && $stable(o_input_b)))
        else $error("Store to channel A misbehaved.");

    AST_STORE_B: assert property (
        s_full_word(3'h1) |=> (o_input_b == $past(data) && $stable(o_dac_a)
            && $stable(o_dac_b) && $stable(o_input_a)))
        else $error("Store to channel B misbehaved.");

    AST_UPDATE_A: assert property (
        s_full_word(3'h2) |=> (o_input_a == $past(data) && o_dac_a == $past(data)
            && $stable(o_dac_b) && $stable(o_input_b)))
        else $error("Update of channel A misbehaved.");

    AST_UPDATE_A_XFER_B: assert property (
        s_full_word(3'h3) |=> (o_dac_a == $past(data) && o_input_a == $past(data)
            && o_dac_b == $past(o_input_b)))
        else $error("Update A with transfer B misbehaved.");

    AST_UPDATE_B: assert property (
        s_full_word(3'h4) |=> (o_input_b == $past(data) && o_dac_b == $past(data)
            && $stable(o_dac_a) && $stable(o_input_a)))
        else $error("Update of channel B misbehaved.");

    AST_UPDATE_B_XFER_A: assert property (
        s_full_word(3'h5) |=> (o_dac_b == $past(data) && o_input_b == $past(data)
            && o_dac_a == $past(o_input_a)))
        else $error("Update B with transfer A misbehaved.");

    AST_UPDATE_ALL: assert property (
        s_full_word(3'h6) |=> (o_dac_a == $past(data) && o_dac_b == $past(data)
            && o_input_a == $past(data) && o_input_b == $past(data)))
        else $error("All-channel update misbehaved.");

    AST_XFER_ALL: assert property (
        s_full_word(3'h7) |=> (o_dac_a == $past(o_input_a) && o_dac_b == $past(o_input_b)
            && $stable(o_input_a) && $stable(o_input_b)))
        else $error("All-channel transfer misbehaved.");

    AST_NO_ACTION_OFF_FRAME: assert property (
        !take |=> ($stable(o_dac_a) && $stable(o_dac_b) && $stable(o_input_a)
            && $stable(o_input_b) && !o_power_down_valid))
        else $error("Registers changed without a complete frame.");

    AST_POWER_DOWN_ROUTE: assert property (
        (take && pd_cmd) |=> (o_power_down_valid && o_power_down_word == $past(link_word)
            && $stable(o_dac_a) && $stable(o_dac_b) && $stable(o_input_a)
            && $stable(o_input_b)) ##1 !o_power_down_valid)
        else $error("Power-down word not routed cleanly.");

    AST_SHORT_WORD_IGNORED: assert property (
        (s_frame_rise ##0 (link_count != dac_cmd_pkg::WORD_COUNT)) |=>
            ($stable(o_dac_a) && $stable(o_input_a) && !o_power_down_valid))
        else $error("Word of wrong length was acted on.");

    AST_RESET_ZERO: assert property (disable iff (!i_rst_n)
        $rose(rst_all_n) |-> (o_dac_a == 12'h000 && o_dac_b == 12'h000
            && o_input_a == 12'h000 && o_input_b == 12'h000))
        else $error("Registers not zero after reset release.");
endmodule : dual_dac_serial_command_port
`default_nettype wire

//--- verilog/serial_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_rx #(
    parameter int WORD_BITS = dac_cmd_pkg::WORD_BITS
) (
    input wire logic i_shift_clk,
    input wire logic i_rst_n,
    input wire logic i_frame_n,
    input wire logic i_serial_word_in,
    input wire logic i_chain_mode_select,
    output logic [WORD_BITS-1:0] o_word,
    output logic [dac_cmd_pkg::COUNT_BITS-1:0] o_bit_count,
    output logic o_serial_chain_out
);
    typedef struct packed {
        logic [WORD_BITS-1:0] word;
        logic [dac_cmd_pkg::COUNT_BITS-1:0] count;
        logic seen_tog;
        logic chain_out;
        logic mode_s1;
        logic mode_s2;
    } link_state_type;

    link_state_type st_ff;
    link_state_type nxt_st;
    logic start_tog_ff;

    if (WORD_BITS != dac_cmd_pkg::WORD_BITS) begin : g_check
        $error("serial_link_rx supports only the 16-bit command word");
    end

    // Each falling frame strobe marks a new word; the toggle lets the shift
    // clock logic see it even when no shift edge fell while the strobe was high.
    always_ff @(negedge i_frame_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_tog_ff <= 1'b0;
        end else begin
            start_tog_ff <= ~start_tog_ff;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.mode_s1 = i_chain_mode_select;
        nxt_st.mode_s2 = st_ff.mode_s1;
        nxt_st.chain_out = st_ff.mode_s2 & st_ff.word[WORD_BITS-1];
        if (!i_frame_n) begin
            nxt_st.word = {st_ff.word[WORD_BITS-2:0], i_serial_word_in};
            if (st_ff.seen_tog != start_tog_ff) begin
                nxt_st.seen_tog = start_tog_ff;
                nxt_st.count = 5'h01;
            end else if (st_ff.count != dac_cmd_pkg::COUNT_MAX) begin
                nxt_st.count = st_ff.count + 5'h01;
            end
        end
    end

    always_ff @(negedge i_shift_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_word = st_ff.word;
    assign o_bit_count = st_ff.count;
    assign o_serial_chain_out = st_ff.chain_out;
endmodule : serial_link_rx
`default_nettype wire
